//--- math_logic_blocks.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "mathblk_cfg.svh"
module math_logic_blocks
   import mathblk_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYC
)(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // register bus
   input  wire axiReq_t              axiReq,
   output axiRsp_t                   axiRsp,
   // sources from other function blocks
   input  wire val_t [`NEXT-1:0]     srcIn,
   // block results
   output val_t [`NMATH-1:0]         mathOut,
   output logic [`NCOND-1:0]         condOut,
   output logic [`NLAT-1:0]          latchOut
);

   logic [1:0]               rstPipe;
   logic                     rstS;
   regs_t                    q;
   regs_t                    d;
   val_t [`NIN-1:0]          pin;
   val_t [`NSTG-1:0]         sRes;
   val_t [`NSTG-1:0]         opB;
   logic [`NSTG-1:0][2:0]    stgB;
   logic [`NSTG-1:0][3:0]    stgOp;
   logic [`NLAT-1:0]         nSet;
   logic [`NLAT-1:0]         nClr;
   logic [`NCOND-1:0]        cRes1;
   logic [`NCOND-1:0]        cRes2;

   function automatic val_t clampPct(input logic signed [63:0] v);
      clampPct = val_t'(v);
      if (v < 0)
         clampPct = '0;
      else if (v > `PCT_FS)
         clampPct = val_t'(`PCT_FS);
   endfunction

   // limits held with fewer decimals are brought to the source resolution
   function automatic val_t decScale(input logic [1:0] dig);
      case (dig)
         2'h0:    decScale = 32'sh3E8;
         2'h1:    decScale = 32'sh64;
         2'h2:    decScale = 32'shA;
         default: decScale = 32'sh1;
      endcase
   endfunction

   function automatic val_t srcVal(input logic [3:0] c,
                                   input val_t [`NEXT-1:0] ext,
                                   input val_t [`NMATH-1:0] m);
      srcVal = '0;
      if (c >= 4'h1 && c < `SRC_MATH)
         srcVal = ext[3'(c - 4'h1)];
      else if (c >= `SRC_MATH && c <= `SRC_LAST)
         srcVal = m[3'(c - `SRC_MATH)];
   endfunction

   function automatic val_t pick(input val_t [`NIN-1:0] p,
                                 input logic [2:0] s);
      pick = '0;
      if (s != 3'h0 && s <= 3'(`NIN))
         pick = p[s - 3'h1];
   endfunction

   function automatic val_t norm(input val_t x, input val_t mn,
                                 input val_t mx);
      logic signed [63:0] span;
      span = 64'(mx) - 64'(mn);
      norm = '0;
      if (span > 0)
         norm = clampPct((64'(x) - 64'(mn)) * `PCT_FS / span);
   endfunction

   function automatic val_t stageOp(input mathOp_t op, input val_t a,
                                    input val_t b);
      logic               t;
      logic               ta;
      logic               tb;
      logic signed [63:0] r;
      t = 1'b0;
      r = 64'(a);
      ta = a >= `PCT_ONE;
      tb = b >= `PCT_ONE;
      case (op)
         OP_EQ:   t = a == b;
         OP_NE:   t = a != b;
         OP_GT:   t = a > b;
         OP_GE:   t = a >= b;
         OP_LT:   t = a < b;
         OP_LE:   t = a <= b;
         OP_OR:   t = ta | tb;
         OP_AND:  t = ta & tb;
         OP_XOR:  t = ta ^ tb;
         OP_ADD:  r = 64'(a) + 64'(b);
         OP_SUB:  r = 64'(a) - 64'(b);
         OP_MUL:  r = 64'(a) * 64'(b) / `PCT_FS;
         OP_DIV:  r = (b == 0) ? 64'(`PCT_FS) : 64'(a) * `PCT_FS / 64'(b);
         OP_MIN:  r = (a < b) ? 64'(a) : 64'(b);
         OP_MAX:  r = (a > b) ? 64'(a) : 64'(b);
         default: r = 64'(a);
      endcase
      if (op <= OP_XOR)
         stageOp = t ? val_t'(`PCT_ONE) : '0;
      else
         stageOp = clampPct(r);
   endfunction

   function automatic logic condOp(input logic [2:0] op, input val_t a,
                                   input val_t b);
      case (op)
         3'h0:    condOp = a == b;
         3'h1:    condOp = a != b;
         3'h2:    condOp = a > b;
         3'h3:    condOp = a >= b;
         3'h4:    condOp = a < b;
         3'h5:    condOp = a <= b;
         3'h6:    condOp = (a >= 1) | (b >= 1);
         default: condOp = (a >= 1) & (b >= 1);
      endcase
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
      wmerge = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            wmerge[8*i +: 8] = nw[8*i +: 8];
      end
   endfunction

   // raw reset only clears the synchroniser; all else uses the clean copy
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstS = rstPipe[1];

   always_comb
   begin
      int          mb;
      int          lb;
      logic [31:0] w;
      logic [31:0] w0;
      val_t        mn;
      val_t        mx;
      val_t        acc;
      val_t        sv;
      val_t        rv;
      logic [9:0]  wi;
      logic [9:0]  ri;
      mb = 0;
      lb = 0;
      w = '0;
      w0 = '0;
      mn = '0;
      mx = '0;
      acc = '0;
      sv = '0;
      rv = '0;
      wi = q.awAddr[`ADDR_W-1:2];
      ri = axiReq.araddr[`ADDR_W-1:2];
      d = q;
      pin = '0;
      sRes = '0;
      opB = '0;
      stgB = '0;
      stgOp = '0;
      nSet = q.setOn;
      nClr = q.clrOn;
      cRes1 = '0;
      cRes2 = '0;
      d.tick = (q.tick == 24'(TICK_CYCLES - 1)) ? '0 : q.tick + 24'h1; // RULE23
      case (q.st)
         S_IDLE:
         begin
            d.blk = '0;
            if (q.tick == 24'(TICK_CYCLES - 1))
               d.st = S_MATH; // RULE23
         end
         S_MATH:
         begin
            // one math block per cycle keeps a single copy of the datapath
            mb = int'(q.blk) * `MATH_WORDS; // RULE1
            for (int i = 0; i < `NIN; i++)
            begin
               w = q.cfg[mb + i * `IN_WORDS];
               if (w[3:0] >= `SRC_MATH && w[3:0] <= `SRC_LAST)
               begin
                  lb = int'(w[3:0] - `SRC_MATH) * `MATH_WORDS;
                  mn = q.cfg[lb + `OMIN_OFS]; // RULE13
                  mx = q.cfg[lb + `OMAX_OFS]; // RULE13
               end
               else
               begin
                  mn = q.cfg[mb + i * `IN_WORDS + 1];
                  mx = q.cfg[mb + i * `IN_WORDS + 2];
                  mn = mn * decScale(w[5:4]); // RULE3
                  mx = mx * decScale(w[5:4]); // RULE3
               end
               pin[i] = norm(srcVal(w[3:0], srcIn, q.mathOut), mn, mx); // RULE2
            end
            w = q.cfg[mb + `STG_OFS];
            acc = pick(pin, w[10:8]); // RULE4
            for (int s = 0; s < `NSTG; s++)
            begin
               w = q.cfg[mb + `STG_OFS + s];
               stgB[s] = w[6:4];
               stgOp[s] = w[3:0];
               opB[s] = pick(pin, w[6:4]);
               if (w[6:4] != 3'h0) // RULE5
                  acc = stageOp(mathOp_t'(w[3:0]), acc, opB[s]); // RULE4 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
               sRes[s] = acc;
            end
            mn = q.cfg[mb + `OMIN_OFS];
            mx = q.cfg[mb + `OMAX_OFS];
            d.mathOut[q.blk] = val_t'(64'(mn) + 64'(acc)
                               * (64'(mx) - 64'(mn)) / `PCT_FS); // RULE13
            d.blk = q.blk + 3'h1;
            if (q.blk == 3'(`NMATH - 1))
               d.st = S_COND;
         end
         S_COND:
         begin
            for (int c = 0; c < `NCOND; c++)
            begin
               w = q.cfg[`COND_BASE + c];
               cRes1[c] = condOp(w[`F_OP1 +: 3],
                                 srcVal(w[3:0], srcIn, q.mathOut),
                                 srcVal(w[7:4], srcIn, q.mathOut)); // RULE14 RULE15 RULE16
               cRes2[c] = condOp(w[`F_OP2 +: 3],
                                 srcVal(w[11:8], srcIn, q.mathOut),
                                 srcVal(w[15:12], srcIn, q.mathOut)); // RULE14 RULE16
               case (w[`F_OP3 +: 2])
                  2'h0:    d.condOut[c] = cRes1[c] | cRes2[c]; // RULE18
                  2'h1:    d.condOut[c] = cRes1[c] & cRes2[c]; // RULE18
                  2'h2:    d.condOut[c] = cRes1[c] ^ cRes2[c]; // RULE18
                  default: d.condOut[c] = 1'b0;
               endcase
            end
            d.st = S_LAT;
         end
         S_LAT:
         begin
            for (int l = 0; l < `NLAT; l++)
            begin
               lb = `LAT_BASE + l * `LAT_WORDS;
               w0 = q.cfg[lb];
               sv = srcVal(w0[3:0], srcIn, q.mathOut);
               rv = srcVal(w0[7:4], srcIn, q.mathOut);
               w = q.cfg[lb + 1];
               if (sv >= val_t'(signed'(w[31:16])))
                  nSet[l] = 1'b1; // RULE22
               else if (sv <= val_t'(signed'(w[15:0])))
                  nSet[l] = 1'b0; // RULE22
               w = q.cfg[lb + 2];
               if (rv >= val_t'(signed'(w[31:16])))
                  nClr[l] = 1'b1; // RULE22
               else if (rv <= val_t'(signed'(w[15:0])))
                  nClr[l] = 1'b0; // RULE22
               if (nClr[l])
                  d.latOut[l] = 1'b0; // RULE20
               else if (nSet[l])
                  d.latOut[l] = 1'b1; // RULE21
            end
            d.setOn = nSet;
            d.clrOn = nClr;
            d.st = S_IDLE;
         end
         default: d.st = S_IDLE;
      endcase
      // register bus write side
      if (axiReq.awvalid && q.rsp.awready)
      begin
         d.awGot = 1'b1;
         d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && q.rsp.wready)
      begin
         d.wGot = 1'b1;
         d.wData = axiReq.wdata;
         d.wStrb = axiReq.wstrb;
      end
      if (q.rsp.bvalid && axiReq.bready)
         d.rsp.bvalid = 1'b0;
      if (q.awGot && q.wGot && !q.rsp.bvalid)
      begin
         d.awGot = 1'b0;
         d.wGot = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = `RESP_ERR;
         if (wi < `NCFG)
         begin
            d.cfg[wi] = wmerge(q.cfg[wi], q.wData, q.wStrb);
            d.rsp.bresp = `RESP_OK;
         end
      end
      d.rsp.awready = !d.awGot;
      d.rsp.wready = !d.wGot;
      // register bus read side
      if (q.rsp.rvalid && axiReq.rready)
         d.rsp.rvalid = 1'b0;
      if (axiReq.arvalid && q.rsp.arready)
      begin
         d.rsp.rvalid = 1'b1;
         d.rsp.rresp = `RESP_OK;
         d.rsp.rdata = '0;
         if (ri < `NCFG)
            d.rsp.rdata = q.cfg[ri];
         else if (ri >= `STAT_IDX && ri < `STAT_IDX + `NMATH)
            d.rsp.rdata = q.mathOut[3'(ri - `STAT_IDX)];
         else if (ri == `STAT_IDX + `NMATH)
            d.rsp.rdata = {20'h0, q.st, q.latOut, q.condOut};
         else
            d.rsp.rresp = `RESP_ERR;
      end
      d.rsp.arready = !d.rsp.rvalid;
   end

   always_ff @(posedge mclk or negedge rstS)
   begin
      if (!rstS)
      begin
         q <= '0;
         q.st <= S_IDLE;
         for (int c = 0; c < `NCOND; c++)
         begin
            q.cfg[`COND_BASE + c][`F_OP1 +: 3] <= `COND_OR; // RULE17
            q.cfg[`COND_BASE + c][`F_OP2 +: 3] <= `COND_OR; // RULE17
         end
      end
      else
         q <= d;
   end

   assign axiRsp = q.rsp;
   assign mathOut = q.mathOut;
   assign condOut = q.condOut;
   assign latchOut = q.latOut;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstS);

   a_latch_clear: assert property ( // RULE20
      q.st == S_LAT && nClr[0] |=> !q.latOut[0])
      else $error("latch not forced off by clear");
   a_latch_set: assert property ( // RULE21
      q.st == S_LAT && !nClr[0] && nSet[0] |=> q.latOut[0])
      else $error("latch not set");
   a_latch_hold: assert property ( // RULE21
      q.st != S_LAT |=> $stable(q.latOut))
      else $error("latch moved outside evaluation");
   a_norm_range: assert property ( // RULE2
      q.st == S_MATH |-> pin[0] >= 0 && pin[0] <= `PCT_FS)
      else $error("normalised input out of range");
   a_div_zero: assert property ( // RULE12
      q.st == S_MATH && stgOp[0] == OP_DIV && stgB[0] != 3'h0
      && opB[0] == 0 |-> sRes[0] == `PCT_FS)
      else $error("zero divisor not full scale");
   a_logic_bool: assert property ( // RULE10
      q.st == S_MATH && stgOp[0] <= OP_XOR && stgB[0] != 3'h0
      |-> sRes[0] == 0 || sRes[0] == `PCT_ONE)
      else $error("logic result not boolean");
   a_stage_pass: assert property ( // RULE5
      q.st == S_MATH && stgB[1] == 3'h0 |-> sRes[1] == sRes[0])
      else $error("unused stage altered value");
   a_sat_range: assert property ( // RULE11
      q.st == S_MATH |-> sRes[3] >= 0 && sRes[3] <= `PCT_FS)
      else $error("result not saturated");
   a_eval_walk: assert property ( // RULE23
      $rose(q.st == S_MATH) |-> (q.st == S_MATH)[*5] ##1
      q.st == S_COND ##1 q.st == S_LAT ##1 q.st == S_IDLE)
      else $error("evaluation sequence broken");
   a_cond_xor: assert property ( // RULE18
      q.st == S_COND && q.cfg[`COND_BASE][`F_OP3 +: 2] == 2'h2
      |=> q.condOut[0] == $past(cRes1[0] ^ cRes2[0]))
      else $error("combining xor wrong");
   a_cond_default: assert property ( // RULE17
      $rose(rstS) |-> q.cfg[`COND_BASE][`F_OP1 +: 3] == `COND_OR)
      else $error("condition operator not OR at reset");

endmodule // math_logic_blocks

//--- mathblk_cfg.svh
// Summary of operation
// RULE1: five math blocks, each taking up to six selectable inputs.
// RULE2: each math input is normalised to percent of its min/max span.
// RULE3: per-input decimal digits raise resolution of data and limits; the code scales only the limits, by decScale.
// RULE4: stage results chain into next operand A; only stage one selects A.
// RULE5: operand B source zero passes operand A through unchanged.
// RULE6: operator codes 0 to 5 are =, !=, >, >=, <, <=.
// RULE7: operator codes 6, 7, 8 are OR, AND, XOR.
// RULE8: operator codes 9 to 14 are add, sub, mul, div, min, max.
// RULE9: a logic operand of at least one is true, else false.
// RULE10: codes 0 to 8 yield only zero or one.
// RULE11: arithmetic results saturate to the 0 to 100 percent range.
// RULE12: division by zero yields 100 percent.
// RULE13: result maps onto output range, which also limits downstream users.
// RULE14: conditional joins two comparisons through a third logical operator.
// RULE15: an argument with no source reads as zero.
// RULE16: condition codes 0 to 7 are =, !=, >, >=, <, <=, OR, AND.
// RULE17: both condition operators reset to OR.
// RULE18: combining codes 0, 1, 2 are OR, AND, XOR.
// RULE19: with one condition in use, software sets the combining operator OR.
// RULE20: latch starts OFF; clear ON forces it OFF.
// RULE21: set alone turns latch ON; both OFF holds state.
// RULE22: latch inputs switch at min/max thresholds, holding in between.
// RULE23: all blocks recompute once per evaluation tick in fixed point.
`ifndef MATHBLK_CFG_SVH
`define MATHBLK_CFG_SVH
`define NMATH 5
`define NIN 6
`define NSTG 4
`define NCOND 4
`define NLAT 4
`define NEXT 8
`define PCT_FS 10000
`define PCT_ONE 100
`define CLK_NS 5
`define TICK_US 1000
`define TICK_CYC (`TICK_US * 1000 / `CLK_NS)
`define ADDR_W 12
`define MATH_WORDS 24
`define IN_WORDS 3
`define STG_OFS 18
`define OMIN_OFS 22
`define OMAX_OFS 23
`define COND_BASE 120
`define LAT_BASE 124
`define LAT_WORDS 3
`define NCFG 136
`define STAT_IDX 256
`define SRC_MATH 4'h9
`define SRC_LAST 4'hD
`define F_OP1 16
`define F_OP2 19
`define F_OP3 22
`define COND_OR 3'h6
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

//--- mathblk_pkg.sv
package mathblk_pkg;
`include "mathblk_cfg.svh"
   typedef logic signed [31:0] val_t;
   typedef enum logic [3:0] {
      OP_EQ  = 4'h0, OP_NE  = 4'h1, OP_GT  = 4'h2, OP_GE  = 4'h3,
      OP_LT  = 4'h4, OP_LE  = 4'h5, OP_OR  = 4'h6, OP_AND = 4'h7,
      OP_XOR = 4'h8, OP_ADD = 4'h9, OP_SUB = 4'hA, OP_MUL = 4'hB,
      OP_DIV = 4'hC, OP_MIN = 4'hD, OP_MAX = 4'hE
   } mathOp_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h1, S_MATH = 4'h2, S_COND = 4'h4, S_LAT = 4'h8
   } evalState_t;
   typedef struct packed {
      logic               awvalid;
      logic [`ADDR_W-1:0] awaddr;
      logic               wvalid;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic               bready;
      logic               arvalid;
      logic [`ADDR_W-1:0] araddr;
      logic               rready;
   } axiReq_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axiRsp_t;
   typedef struct packed {
      evalState_t             st;
      logic [2:0]             blk;
      logic [23:0]            tick;
      logic [`NCFG-1:0][31:0] cfg;
      val_t [`NMATH-1:0]      mathOut;
      logic [`NCOND-1:0]      condOut;
      logic [`NLAT-1:0]       latOut;
      logic [`NLAT-1:0]       setOn;
      logic [`NLAT-1:0]       clrOn;
      logic                   awGot;
      logic                   wGot;
      logic [`ADDR_W-1:0]     awAddr;
      logic [31:0]            wData;
      logic [3:0]             wStrb;
      axiRsp_t                rsp;
   } regs_t;
endpackage

//--- src_blocks.sv
`timescale 1ns/1ps
`include "mathblk_cfg.svh"
module src_blocks
   import mathblk_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // load port from bench
   input  wire logic        load,
   input  wire logic [2:0]  idx,
   input  wire val_t        val,
   // values seen by the block
   output val_t [`NEXT-1:0] srcIn
);
   // registered like any real block output, so a value lands one edge late
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
         srcIn <= '0;
      else if (load)
         srcIn[idx] <= val;
endmodule // src_blocks

//--- tb_configurable_math_logic_latch_blocks.sv
`timescale 1ns/1ps
`include "mathblk_cfg.svh"
module tb_configurable_math_logic_latch_blocks
   import mathblk_pkg::*;
;
   localparam int TICK = 16;
   localparam int EXP_OP [15] = '{0, 100, 100, 100, 0, 0, 100, 100, 0,
                                  9000, 3000, 1800, 10000, 3000, 6000};
   localparam int LS [6] = '{3000, 0, 0, 3000, 3000, 3000};
   localparam int LC [6] = '{0, 1500, 3000, 1500, 3000, 0};
   localparam logic [5:0] LE = 6'b10_0011;
   localparam logic [7:0] EXP_C = 8'b1100_1110;
   logic                 mclk;
   logic                 rst_n;
   axiReq_t              axiReq;
   axiRsp_t              axiRsp;
   val_t [`NEXT-1:0]     srcIn;
   val_t [`NMATH-1:0]    mathOut;
   logic [`NCOND-1:0]    condOut;
   logic [`NLAT-1:0]     latchOut;
   logic                 load;
   logic [2:0]           idx;
   val_t                 val;
   logic [31:0]          d;
   logic [1:0]           r;
   int                   n_errors;
   int                   cmp_count;

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   math_logic_blocks #(.TICK_CYCLES(TICK)) u_math_logic_blocks (
      .mclk(mclk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
      .srcIn(srcIn), .mathOut(mathOut), .condOut(condOut),
      .latchOut(latchOut));
   src_blocks u_src_blocks (
      .mclk(mclk), .rst_n(rst_n), .load(load), .idx(idx), .val(val),
      .srcIn(srcIn));

   task finish_test;
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   task chk_bit(input string nm, input logic e, input logic g);
      chk_val(nm, {31'h0, e}, {31'h0, g});
   endtask

   task stall(input string nm);
      $display("CHECK FAILED %s expected answer seen none", nm);
      n_errors++;
      finish_test;
   endtask

   task axi_wr(input int i, input logic [31:0] dt, input logic [3:0] s,
               output logic [1:0] rs);
      int n;
      logic ta, tw, tb;
      @(posedge mclk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr  <= 12'(i * 4);
      axiReq.wvalid  <= 1'b1;
      axiReq.wdata   <= dt;
      axiReq.wstrb   <= s;
      axiReq.bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(negedge mclk);
         ta = axiReq.awvalid && axiRsp.awready;
         tw = axiReq.wvalid && axiRsp.wready;
         tb = axiRsp.bvalid;
         rs = axiRsp.bresp;
         @(posedge mclk);
         if (ta)
            axiReq.awvalid <= 1'b0;
         if (tw)
            axiReq.wvalid <= 1'b0;
         if (tb)
         begin
            axiReq.bready <= 1'b0;
            break;
         end
      end
      if (n == 50)
         stall("bvalid");
   endtask

   task axi_rd(input int i, output logic [31:0] dt, output logic [1:0] rs);
      int n;
      logic ta, tr;
      @(posedge mclk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr  <= 12'(i * 4);
      axiReq.rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(negedge mclk);
         ta = axiReq.arvalid && axiRsp.arready;
         tr = axiRsp.rvalid;
         dt = axiRsp.rdata;
         rs = axiRsp.rresp;
         @(posedge mclk);
         if (ta)
            axiReq.arvalid <= 1'b0;
         if (tr)
         begin
            axiReq.rready <= 1'b0;
            break;
         end
      end
      if (n == 50)
         stall("rvalid");
   endtask

   task wr(input int i, input logic [31:0] dt);
      axi_wr(i, dt, 4'hF, r);
   endtask

   task rdchk(input int i, input logic [31:0] e, input string nm);
      axi_rd(i, d, r);
      chk_val(nm, e, d);
   endtask

   task src(input int i, input int v);
      @(posedge mclk);
      load <= 1'b1;
      idx  <= 3'(i);
      val  <= val_t'(v);
      @(posedge mclk);
      load <= 1'b0;
   endtask

   // results only move on a tick, so two full periods always cover one
   task settle;
      repeat (2 * TICK + 2) @(posedge mclk);
      #1;
   endtask

   task do_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask

   task t_reset;
      #1;
      chk_bit("latchOut", 1'b0, latchOut[0]);
      rdchk(`COND_BASE, 32'h0036_0000, "cond cfg");
      rdchk(`STAT_IDX + 5, 32'h0000_0100, "status");
      $display("test reset done");
   endtask

   task t_bus;
      axi_wr(`NCFG, 32'hFFFF_FFFF, 4'hF, r);
      chk_val("bresp", 32'(`RESP_ERR), {30'h0, r});
      axi_rd(`NCFG, d, r);
      chk_val("rresp", 32'(`RESP_ERR), {30'h0, r});
      chk_val("rdata", 32'h0, d);
      axi_rd(`STAT_IDX + 6, d, r);
      chk_val("rresp", 32'(`RESP_ERR), {30'h0, r});
      wr(118, 32'h1234_5678);
      axi_wr(118, 32'hFFFF_FFFF, 4'h1, r);
      rdchk(118, 32'h1234_56FF, "strobe");
      $display("test bus done");
   endtask

   task op_case(input int b, input logic [31:0] w, input int e);
      src(1, b);
      wr(`STG_OFS, w);
      settle;
      chk_val("math case", 32'(e), mathOut[0]);
   endtask

   task t_ops;
      wr(0, 32'h31);
      wr(1, 0);
      wr(2, 10000);
      wr(3, 32'h32);
      wr(4, 0);
      wr(5, 10000);
      wr(`OMAX_OFS, 10000);
      src(0, 6000);
      src(1, 3000);
      for (int k = 0; k < 15; k++)
      begin
         wr(`STG_OFS, 32'h120 | 32'(k));
         settle;
         chk_val("op result", 32'(EXP_OP[k]), mathOut[0]);
      end
      op_case(0, 32'h12C, 10000);
      op_case(99, 32'h127, 0);
      op_case(100, 32'h127, 100);
      op_case(9000, 32'h12A, 0);
      op_case(9000, 32'h109, 6000);
      // one and zero decimals must still span 0 to 10000 on input 2
      wr(3, 32'h12);
      wr(5, 100);
      op_case(3000, 32'h129, 9000);
      wr(3, 32'h02);
      wr(5, 10);
      op_case(3000, 32'h129, 9000);
      $display("test ops done");
   endtask

   task t_chain;
      src(1, 3000);
      src(2, 2000);
      wr(6, 32'h23);
      wr(7, 100);
      wr(8, 300);
      wr(`STG_OFS, 32'h129);
      wr(`STG_OFS + 1, 32'h3B);
      wr(`OMAX_OFS, 200);
      wr(24, 32'h09);
      wr(24 + `STG_OFS, 32'h109);
      wr(24 + `OMAX_OFS, 10000);
      settle;
      chk_val("chain", 32'd90, mathOut[0]);
      rdchk(`STAT_IDX, 32'd90, "status math");
      chk_val("downstream", 32'd4500, mathOut[1]);
      $display("test chain done");
   endtask

   task t_cond;
      src(1, 3000);
      src(2, 5000);
      src(3, 5000);
      for (int k = 0; k < 8; k++)
      begin
         wr(`COND_BASE, 32'h0040_4321 | (32'(k) << `F_OP1));
         settle;
         chk_bit("cond op", EXP_C[k], condOut[0]);
      end
      for (int c = 0; c < 4; c++)
      begin
         wr(`COND_BASE, 32'h000A_4321 | (32'(c) << 22));
         settle;
         chk_bit("combine", c[0] == 1'b0, condOut[0]);
      end
      wr(`COND_BASE, 32'h0008_0000);
      settle;
      chk_bit("no source", 1'b1, condOut[0]);
      $display("test cond done");
   endtask

   task t_latch;
      wr(`LAT_BASE, 32'h21);
      wr(`LAT_BASE + 1, 32'h07D0_03E8);
      wr(`LAT_BASE + 2, 32'h07D0_03E8);
      for (int k = 0; k < 6; k++)
      begin
         src(0, LS[k]);
         src(1, LC[k]);
         settle;
         chk_bit("latch", LE[k], latchOut[0]);
      end
      do_reset;
      #1;
      chk_bit("latch reset", 1'b0, latchOut[0]);
      rdchk(`COND_BASE, 32'h0036_0000, "cond cfg");
      $display("test latch done");
   endtask

   initial
   begin
      rst_n = 1'b0;
      axiReq = '0;
      load = 1'b0;
      idx = 3'h0;
      val = '0;
      n_errors = 0;
      cmp_count = 0;
      do_reset;
      t_reset;
      t_bus;
      t_ops;
      t_chain;
      t_cond;
      t_latch;
      finish_test;
   end
endmodule // tb_configurable_math_logic_latch_blocks
